// [rtl/cst_pkg.sv]
package cst_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // Byte offsets of the three chip-select configuration registers and the three transfer registers.
  localparam logic [11:0] CFG_ONE_OFFS = 12'h004;
  localparam logic [11:0] CFG_TWO_OFFS = 12'h008;
  localparam logic [11:0] CFG_THREE_OFFS = 12'h00C;
  localparam logic [11:0] XFER_CTRL_OFFS = 12'h010;
  localparam logic [11:0] XFER_STAT_OFFS = 12'h014;
  localparam logic [11:0] XFER_DATA_OFFS = 12'h018;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int WAIT_LSB = 0;
  localparam int HOLD_LSB = 4;
  localparam int WIDTH_BIT = 6;
  localparam int SETUP_BIT = 7;
  localparam int EXTW_BIT = 8;
  localparam int HSUP_BIT = 10;
  localparam int POL_BIT = 11;
  localparam int ENA_BIT = 12;
  localparam int UBE_BIT = 13;
  localparam logic [13:0] CFG_RESET = 14'h000F;
  localparam logic [13:0] CFG_WMASK = 14'h3DFF;
  localparam logic [3:0] EXT_MIN_WAIT = 4'h3;

  // Transfer control fields: start(0) write(1) select(3:2) beats-1(7:4).
  localparam int CT_START = 0;
  localparam int CT_WRITE = 1;
  localparam int CT_SEL_LSB = 2;
  localparam int CT_BEATS_LSB = 4;

  typedef struct packed {
    logic byte_enable_use;
    logic select_enable;
    logic select_polarity;
    logic hold_suppress;
    logic unused_bit;
    logic external_wait_enable;
    logic setup_extra;
    logic bus_width_sel;
    logic [1:0] hold_count;
    logic [3:0] wait_count;
  } cst_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WAIT,
    ST_EXTEND,
    ST_HOLD
  } cst_state_t;

endpackage

// [rtl/cst_engine.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic write,
  input wire logic [3:0] beats_m1,
  input wire cst_pkg::cst_cfg_t cfg,
  input wire logic ext_wait_sync,
  output logic busy,
  output logic sel_active,
  output logic strobe,
  output logic beat_done,
  output logic last_beat
);

  cst_pkg::cst_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] beat_reg, beat_next;
  logic [1:0] hold_reg, hold_next;

  wire logic [3:0] wait_load = (cfg.external_wait_enable && cfg.wait_count < cst_pkg::EXT_MIN_WAIT) ?
                                cst_pkg::EXT_MIN_WAIT : cfg.wait_count;
  wire logic is_last = (beat_reg == 4'h0);
  // Suppression only applies between beats of a read, never after the last.
  wire logic skip_hold = cfg.hold_suppress && !write && !is_last; // RULE1 RULE2 RULE3
  wire logic wait_out = (cnt_reg == 4'h1);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    beat_next = beat_reg;
    hold_next = hold_reg;
    case (state_reg)
      cst_pkg::ST_IDLE: begin
        if (start && cfg.select_enable) begin // RULE12
          beat_next = beats_m1;
          cnt_next = wait_load;
          state_next = cfg.setup_extra ? cst_pkg::ST_SETUP : cst_pkg::ST_WAIT; // RULE4
        end
      end
      cst_pkg::ST_SETUP: begin
        state_next = cst_pkg::ST_WAIT;
      end
      cst_pkg::ST_WAIT: begin
        cnt_next = cnt_reg - 4'h1; // RULE8 RULE10
        if (wait_out) begin
          if (cfg.external_wait_enable && ext_wait_sync) begin
            state_next = cst_pkg::ST_EXTEND; // RULE9
          end else if (cfg.hold_count == 2'h0 || skip_hold) begin // RULE7
            state_next = is_last ? cst_pkg::ST_IDLE : cst_pkg::ST_WAIT;
            cnt_next = wait_load;
            beat_next = beat_reg - 4'h1;
          end else begin
            state_next = cst_pkg::ST_HOLD;
            hold_next = cfg.hold_count;
          end
        end
      end
      cst_pkg::ST_EXTEND: begin
        if (!ext_wait_sync) begin // RULE9
          if (cfg.hold_count == 2'h0 || skip_hold) begin
            state_next = is_last ? cst_pkg::ST_IDLE : cst_pkg::ST_WAIT;
            cnt_next = wait_load;
            beat_next = beat_reg - 4'h1;
          end else begin
            state_next = cst_pkg::ST_HOLD;
            hold_next = cfg.hold_count;
          end
        end
      end
      cst_pkg::ST_HOLD: begin
        hold_next = hold_reg - 2'h1; // RULE7
        if (hold_reg == 2'h1) begin
          state_next = is_last ? cst_pkg::ST_IDLE : cst_pkg::ST_WAIT;
          cnt_next = wait_load;
          beat_next = beat_reg - 4'h1;
        end
      end
      default: state_next = cst_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cst_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      beat_reg <= 4'h0;
      hold_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      beat_reg <= beat_next;
      hold_reg <= hold_next;
    end
  end

  assign busy = (state_reg != cst_pkg::ST_IDLE);
  assign sel_active = (state_reg == cst_pkg::ST_WAIT) || (state_reg == cst_pkg::ST_EXTEND);
  assign strobe = sel_active;
  assign beat_done = (state_reg != state_next || cnt_next == wait_load) && sel_active &&
                     (state_next != cst_pkg::ST_EXTEND) && (wait_out || state_reg == cst_pkg::ST_EXTEND) &&
                     !(state_reg == cst_pkg::ST_EXTEND && ext_wait_sync);
  assign last_beat = is_last;

endmodule
`default_nettype wire

// [rtl/cst_top.sv]
// Notes on behaviour
// (RULE1) Hold-suppress skips hold between read beats.
// (RULE2) Without suppress, every beat gets hold states.
// (RULE3) Final beat always gets its hold states.
// (RULE4) Setup bit adds one cycle before select.
// (RULE5) Wide mode moves all sixteen data lines.
// (RULE6) Narrow mode moves data lines 7:0 only.
// (RULE7) Hold field gives zero to three cycles.
// (RULE8) Wait field gives its binary count cycles; zero gives sixteen.
// (RULE9) External wait: minimum three, then extend while held.
// (RULE10) Wait count applies every access; resets to fifteen.
// (RULE11) Polarity bit sets select active level.
// (RULE12) Select asserts only when enabled.
// (RULE13) Software avoids byte writes without byte-enable use.
`timescale 1ns/1ns
`default_nettype none
module cst_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_wait_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic [2:0] select_out,
  output logic mem_read_n,
  output logic mem_write_n
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Only one outstanding transfer; software polls busy before starting another.
  logic [13:0] cfg_reg [3];
  logic [7:0] ctrl_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic start_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic wait_meta_reg, wait_sync_reg;

  wire logic acc = psel && penable;
  wire logic hit_c0 = (paddr == cst_pkg::CFG_ONE_OFFS);
  wire logic hit_c1 = (paddr == cst_pkg::CFG_TWO_OFFS);
  wire logic hit_c2 = (paddr == cst_pkg::CFG_THREE_OFFS);
  wire logic hit_ct = (paddr == cst_pkg::XFER_CTRL_OFFS);
  wire logic hit_st = (paddr == cst_pkg::XFER_STAT_OFFS);
  wire logic hit_dt = (paddr == cst_pkg::XFER_DATA_OFFS);
  wire logic hit_any = hit_c0 || hit_c1 || hit_c2 || hit_ct || hit_st || hit_dt;
  wire logic [1:0] sel_idx = ctrl_reg[cst_pkg::CT_SEL_LSB +: 2];
  wire logic sel_ok = (sel_idx != 2'h3);
  wire cst_pkg::cst_cfg_t cur_cfg = sel_ok ? cst_pkg::cst_cfg_t'(cfg_reg[sel_idx]) : cst_pkg::cst_cfg_t'(14'h0);
  logic busy, sel_active, strobe, beat_done, last_beat;

  wire logic [31:0] rd_mux = hit_c0 ? {18'h0, cfg_reg[0]} :
                             hit_c1 ? {18'h0, cfg_reg[1]} :
                             hit_c2 ? {18'h0, cfg_reg[2]} :
                             hit_ct ? {24'h0, ctrl_reg} :
                             hit_st ? {31'h0, busy} :
                             hit_dt ? {16'h0, rdata_reg} : 32'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cfg
      wire logic hit = (paddr == cst_pkg::CFG_ONE_OFFS + 12'(4 * gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_reg[gi] <= cst_pkg::CFG_RESET; // RULE10
        end else if (acc && pwrite && hit) begin
          cfg_reg[gi] <= pwdata[13:0] & cst_pkg::CFG_WMASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      start_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      // Zero wait states: ready rises in the access phase that follows every setup cycle.
      pready_reg <= psel && !penable;
      start_reg <= acc && pwrite && hit_ct && pwdata[cst_pkg::CT_START] && !busy && !start_reg;
      if (acc && pwrite && hit_ct) begin
        ctrl_reg <= {pwdata[7:1], 1'b0};
      end
      if (acc && pwrite && hit_dt) begin
        wdata_reg <= pwdata[15:0];
      end
      prdata_reg <= rd_mux;
      pslverr_reg <= psel && !penable && !hit_any;
    end
  end

  // ----------------------------------------
  // External wait synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_meta_reg <= 1'b0;
      wait_sync_reg <= 1'b0;
    end else begin
      wait_meta_reg <= external_wait_in;
      wait_sync_reg <= wait_meta_reg; // RULE9
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  cst_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_reg && sel_ok),
    .write(ctrl_reg[cst_pkg::CT_WRITE]),
    .beats_m1(ctrl_reg[cst_pkg::CT_BEATS_LSB +: 4]),
    .cfg(cur_cfg),
    .ext_wait_sync(wait_sync_reg),
    .busy(busy),
    .sel_active(sel_active),
    .strobe(strobe),
    .beat_done(beat_done),
    .last_beat(last_beat)
  );

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Narrow devices see zeros on the upper lane so stale data never leaks.
  wire logic [15:0] wr_lanes = cur_cfg.bus_width_sel ? wdata_reg : {8'h00, wdata_reg[7:0]}; // RULE5 RULE6
  wire logic [15:0] rd_lanes = cur_cfg.bus_width_sel ? data_in : {8'h00, data_in[7:0]}; // RULE5 RULE6
  wire logic [2:0] sel_onehot = (sel_active && cur_cfg.select_enable) ? (3'h1 << sel_idx) : 3'h0; // RULE12
  logic [2:0] pol_vec;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_pol
      assign pol_vec[gi] = cfg_reg[gi][cst_pkg::POL_BIT];
    end
  endgenerate

  logic [2:0] select_reg;
  logic [15:0] dout_reg;
  logic doe_n_reg, rd_n_reg, wr_n_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= 3'h7;
      dout_reg <= 16'h0000;
      doe_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rdata_reg <= 16'h0000;
    end else begin
      select_reg <= sel_onehot ^ ~pol_vec; // RULE11
      dout_reg <= wr_lanes;
      doe_n_reg <= !(busy && ctrl_reg[cst_pkg::CT_WRITE]);
      rd_n_reg <= !(strobe && !ctrl_reg[cst_pkg::CT_WRITE]);
      wr_n_reg <= !(strobe && ctrl_reg[cst_pkg::CT_WRITE]);
      if (beat_done && !ctrl_reg[cst_pkg::CT_WRITE]) begin
        rdata_reg <= rd_lanes;
      end
    end
  end

  assign select_out = select_reg;
  assign data_out = dout_reg;
  assign data_oe_n = doe_n_reg;
  assign mem_read_n = rd_n_reg;
  assign mem_write_n = wr_n_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_select_disabled: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    !cur_cfg.select_enable |-> !sel_active) else $error("select active while disabled");
  a_setup_delay: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (start_reg && sel_ok && cur_cfg.select_enable && cur_cfg.setup_extra) |=> !sel_active ##1 sel_active)
    else $error("setup cycle missing");
  a_wait_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    $rose(presetn) |-> cfg_reg[0][3:0] == 4'hF) else $error("wait field reset wrong");
  a_narrow_lane: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    $past(!cur_cfg.bus_width_sel) |-> data_out[15:8] == 8'h00) else $error("upper lane used in narrow mode");
  a_wide_lane: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    $past(cur_cfg.bus_width_sel) |-> data_out == $past(wdata_reg)) else $error("wide lane mismatch");
  a_pol_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (!busy && $past(!busy)) |-> select_out == ~$past(pol_vec))
    else $error("idle select level wrong");
  a_ext_extend: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (u_engine.state_reg == cst_pkg::ST_EXTEND && wait_sync_reg) |=> sel_active) else $error("extension dropped");
  a_no_hold_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (cur_cfg.hold_count == 2'h0) |-> u_engine.state_next != cst_pkg::ST_HOLD || u_engine.state_reg == cst_pkg::ST_HOLD)
    else $error("hold entered with zero count");
  a_last_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (u_engine.state_reg == cst_pkg::ST_WAIT && u_engine.wait_out && last_beat && !cur_cfg.external_wait_enable &&
     cur_cfg.hold_count != 2'h0) |=> u_engine.state_reg == cst_pkg::ST_HOLD) else $error("final hold skipped");
  a_min_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    $rose(sel_active) && cur_cfg.wait_count == 4'h4 && !cur_cfg.external_wait_enable |-> sel_active[*4])
    else $error("wait too short");

endmodule
`default_nettype wire

// [tb/cst_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_mem_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic [2:0] select_out,
  input wire logic [2:0] pol,
  input wire logic [1:0] idx,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic data_oe_n,
  input wire logic [15:0] data_out,
  input wire logic [15:0] rpat,
  input wire logic [3:0] ext_hold,
  output logic [15:0] data_in,
  output logic external_wait_in,
  output logic [15:0] wdat,
  output int act,
  output int gap,
  output int lat,
  output logic stray
);
  // ----------------------------------------
  // Far-side memory
  // ----------------------------------------
  logic [2:0] on;
  logic [15:0] last = 16'h0000;
  int pend;
  int ew;
  assign on = ~(select_out ^ pol);
  // Released read lines toggle every cycle so a late sample cannot pass by luck.
  assign data_in = (on[idx] && !mem_read_n) ? rpat : ~last;
  assign external_wait_in = ew != 0;
  always @(posedge pclk) begin
    last <= data_in;
    if (on[idx] && !mem_write_n && !data_oe_n) begin
      wdat <= data_out;
    end
    if (clr) begin
      act <= 0;
      gap <= 0;
      pend <= 0;
      lat <= 0;
      // Wait is held from the start so it survives the two-flop synchroniser in time.
      ew <= ext_hold;
      stray <= 1'b0;
    end else begin
      if ((on & ~(3'h1 << idx)) != 3'h0) begin
        stray <= 1'b1;
      end
      if (on[idx]) begin
        act <= act + 1;
        gap <= gap + pend;
        pend <= 0;
      end else if (act != 0) begin
        pend <= pend + 1;
      end else begin
        lat <= lat + 1;
      end
      if (on[idx] && ew != 0) begin
        ew <= ew - 1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/cst_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_top_tb_top;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ewi, data_oe_n, mem_read_n, mem_write_n, stray, w;
  logic [15:0] data_in, data_out, wdat, wd;
  logic [15:0] rpat = 16'h0000;
  logic [2:0] select_out;
  logic [2:0] pol = 3'h0;
  logic [1:0] idx = 2'h0;
  logic [1:0] s;
  logic [3:0] ext_hold = 4'h0;
  logic [3:0] bm;
  logic [13:0] v;
  logic clr = 1'b1;
  int act, gap, lat, l0, n;
  int err_count = 0;
  int tests_run = 0;
  int seed = 97882;
  always #20 pclk = ~pclk;
  cst_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_wait_in(ewi), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .select_out(select_out), .mem_read_n(mem_read_n), .mem_write_n(mem_write_n));
  cst_mem_model u_mem (.pclk(pclk), .clr(clr), .select_out(select_out), .pol(pol), .idx(idx),
    .mem_read_n(mem_read_n), .mem_write_n(mem_write_n), .data_oe_n(data_oe_n), .data_out(data_out),
    .rpat(rpat), .ext_hold(ext_hold), .data_in(data_in), .external_wait_in(ewi), .wdat(wdat),
    .act(act), .gap(gap), .lat(lat), .stray(stray));
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic logic [11:0] offs(input logic [1:0] k);
    offs = (k == 2'h0) ? cst_pkg::CFG_ONE_OFFS : (k == 2'h1) ? cst_pkg::CFG_TWO_OFFS : cst_pkg::CFG_THREE_OFFS;
  endfunction
  function automatic int exp_gap(input logic [13:0] c, input logic wr, input logic [3:0] b);
    exp_gap = (c[cst_pkg::HSUP_BIT] && !wr) ? 0 : b * c[5:4];
  endfunction
  // Master holds the whole request until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(1'b0, "no pready");
      test_done;
    end
  endtask
  task automatic cfgw(input logic [1:0] k, input logic [13:0] c);
    apb(1'b1, offs(k), {18'h0, c});
    pol[k] <= c[cst_pkg::POL_BIT];
  endtask
  task automatic xfer(input logic [1:0] k, input logic wr, input logic [3:0] b);
    clr <= 1'b1;
    idx <= k;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, cst_pkg::XFER_CTRL_OFFS, {24'h0, b, k, wr, 1'b1});
    n = 0;
    do begin
      apb(1'b0, cst_pkg::XFER_STAT_OFFS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (rd[0] !== 1'b0) begin
      chk(1'b0, "stuck busy");
      test_done;
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, offs(i[1:0]), 32'h0);
      chk(rd === 32'h0000000F, "cfg reset value");
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(er === 1'b1, "unmapped not refused");
    repeat (24) begin
      s = 2'($unsigned($random(seed)) % 3);
      v = 14'($random(seed));
      v[3:0] = 4'(2 + $unsigned($random(seed)) % 14);
      v[cst_pkg::ENA_BIT] = 1'b1;
      v[cst_pkg::SETUP_BIT] = 1'b0;
      v[cst_pkg::EXTW_BIT] = 1'b0;
      cfgw(s, v);
      apb(1'b0, offs(s), 32'h0);
      chk(rd === {18'h0, v & cst_pkg::CFG_WMASK}, "cfg readback");
      w = 1'($random(seed));
      bm = 4'($unsigned($random(seed)) % 4);
      wd = 16'($random(seed));
      rpat <= 16'($random(seed));
      apb(1'b1, cst_pkg::XFER_DATA_OFFS, {16'h0, wd});
      xfer(s, w, bm);
      chk(act == (bm + 1) * v[3:0], "wait cycles");
      chk(gap == exp_gap(v, w, bm), "hold between beats");
      chk(stray === 1'b0, "wrong select level");
      if (w) begin
        chk(wdat[7:0] === wd[7:0] && (!v[6] || wdat[15:8] === wd[15:8]), "write lines");
      end else begin
        apb(1'b0, cst_pkg::XFER_DATA_OFFS, 32'h0);
        chk(rd[15:0] === (v[6] ? rpat : {8'h00, rpat[7:0]}), "read lines");
      end
    end
    cfgw(2'h0, 14'h1004);
    xfer(2'h0, 1'b0, 4'h0);
    l0 = lat;
    cfgw(2'h0, 14'h1084);
    xfer(2'h0, 1'b0, 4'h0);
    chk(lat == l0 + 1 && act == 4, "setup cycle");
    cfgw(2'h1, 14'h0005);
    xfer(2'h1, 1'b1, 4'h1);
    chk(act == 0 && stray === 1'b0, "disabled select active");
    cfgw(2'h2, 14'h1102);
    xfer(2'h2, 1'b0, 4'h0);
    chk(act == 3, "external wait minimum");
    ext_hold <= 4'h6;
    xfer(2'h2, 1'b0, 4'h0);
    chk(act > 3 && act <= 12, "external wait stretch");
    test_done;
  end
endmodule
`default_nettype wire
